// *** rtl/scbp_pkg.sv ***
package scbp_pkg;

  // ----------------------------------------------------------------
  // clocking and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 125_000_000; // core clock rate
  localparam int unsigned SCK_HZ = 1_024_000; // default master serial clock
  localparam int unsigned SCK_HALF_CYC = (CLK_HZ + 2 * SCK_HZ - 1) / (2 * SCK_HZ);
  localparam int unsigned BOOT_LATCH_NS = 1000; // boot pin sampled this long after reset
  localparam int unsigned BOOT_LATCH_CYC = (BOOT_LATCH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // ----------------------------------------------------------------
  // memory loader constants
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_READ = 8'h03; // memory read opcode
  localparam logic [15:0] LOAD_START_ADDR = 16'h0010; // first command location
  localparam logic [5:0] CMD_XFER_BITS = 6'h20; // 4-byte command fetch
  localparam logic [5:0] DATA_XFER_BITS = 6'h30; // 6-byte data fetch
  localparam logic [10:0] REGW_WORDS = 11'h002; // address and value
  localparam logic [10:0] IIR_WORDS = 11'h008; // fixed coefficient count
  localparam logic [1:0] FIR_HDR_WORDS = 2'h2; // two counts lead the coefficients
  localparam logic [1:0] TBS_HDR_WORDS = 2'h1; // one count leads the data

  typedef enum logic [7:0] {
    CMD_NOP = 8'h00,
    CMD_REG_WRITE = 8'h01,
    CMD_FIR = 8'h02,
    CMD_IIR = 8'h03,
    CMD_ROM_COEF = 8'h04,
    CMD_TBS = 8'h05,
    CMD_ROM_TBS = 8'h06,
    CMD_FILTER_START = 8'h07
  } scbp_cmd_t;

  typedef enum logic [2:0] {
    ST_WAIT = 3'b000,
    ST_START = 3'b001,
    ST_SHIFT = 3'b010,
    ST_END = 3'b011,
    ST_DECODE = 3'b100,
    ST_SLAVE = 3'b101
  } scbp_state_t;

  // one fetched item of the boot stream
  typedef struct packed {
    logic valid;
    logic is_cmd;
    logic [7:0] cmd;
    logic [23:0] word;
  } scbp_item_t;

  // one byte received in slave operation
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } scbp_rx_t;

endpackage

// *** rtl/scbp_slave_link.sv ***
`timescale 1ns/100ps
// slave side of the port, clocked by the external serial clock
module scbp_slave_link (
  input wire logic sck, // serial clock from the external master
  input wire logic rstn, // core reset, asynchronous here
  input wire logic slave_select_in_n, // raw select pin
  input wire logic mosi, // serial data in
  output logic miso, // serial data out
  output logic [7:0] rx_byte, // last whole byte
  output logic rx_toggle // flips on every whole byte
);

  // ----------------------------------------------------------------
  // bit counter, cleared whenever the frame is not selected
  // ----------------------------------------------------------------
  logic [2:0] bit_cnt_q; // bits of current byte
  logic [6:0] shift_q; // bits gathered so far
  logic [7:0] tx_q; // outgoing shifter

  // select high holds the counter at zero between frames
  always_ff @(posedge sck or posedge slave_select_in_n) begin
    if (slave_select_in_n) begin
      bit_cnt_q <= 3'h0;
    end else begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // receive on rising edge, msb first
  // ----------------------------------------------------------------
  always_ff @(posedge sck or negedge rstn) begin
    if (!rstn) begin
      shift_q <= 7'h00;
      rx_byte <= 8'h00;
      rx_toggle <= 1'b0;
    end else begin
      shift_q <= {shift_q[5:0], mosi};
      // eighth bit completes the byte, held until the next one
      if (bit_cnt_q == 3'h7) begin
        rx_byte <= {shift_q, mosi};
        rx_toggle <= ~rx_toggle;
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit on falling edge, echo of the previous byte
  // ----------------------------------------------------------------
  always_ff @(negedge sck or negedge rstn) begin
    if (!rstn) begin
      tx_q <= 8'h00;
    end else if (bit_cnt_q == 3'h0) begin
      tx_q <= rx_byte;
    end else begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  assign miso = tx_q[7];

endmodule // scbp_slave_link

// *** rtl/scbp_sync.sv ***
`timescale 1ns/100ps
// two-stage synchroniser for levels entering the core clock domain
module scbp_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] meta; // first stage, read only by second
    logic [W-1:0] sync; // second stage
  } scbp_sync_t;

  scbp_sync_t s_q, s_d;

  // next state: shift the chain
  always_comb begin
    s_d.meta = din;
    s_d.sync = s_q.meta;
  end

  // register with synchronous reset
  always_ff @(posedge clock) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.sync;

endmodule // scbp_sync

// *** rtl/scbp_top.sv ***
// Notes on behaviour
// - master only during memory boot, then slave
// - master drives select, clock, mosi; samples miso
// - memory addresses 16-bit, slave addresses 8-bit
// - select low gives default slave configuration
// - data changes falling, sampled rising clock
// - master serial clock 1.024 MHz asked, 124 core cycles per period gives about 1.008 MHz
// - reserved interrupt, mirror, spare selects held inactive
// - fetch command bytes and data words until start
// - start command starts filters, enters slave
// - loading begins at location 0x10
// - each command fetches its own data word count
// - register, fir, iir, test data, start commands
// - command fetch: opcode, address, one byte
// - data fetch: opcode, address, three bytes
// - all serial data most significant first
// - boot pin low slave, high memory boot
`timescale 1ns/100ps
module scbp_top (
  input wire logic clock,
  input wire logic rstn,
  input wire logic sck_link, // external serial clock in slave operation
  input wire logic boot_select, // boot pin
  input wire logic slave_select_in_n, // slave select pin
  input wire logic mosi_in,
  input wire logic miso_in,
  output logic port_serial_clock_out,
  output logic port_serial_clock_oe,
  output logic mosi_out,
  output logic mosi_oe,
  output logic miso_out,
  output logic miso_oe,
  output logic memory_select_out_n, // on the shared io line
  output logic shared_io_oe,
  output logic port_interrupt_out_n,
  output logic select_mirror_out_n,
  output logic [2:0] spare_master_selects_n,
  output scbp_pkg::scbp_item_t load_item, // fetched boot stream
  output logic filters_start, // pulse on the start command
  output logic master_active, // level while booting from memory
  output scbp_pkg::scbp_rx_t slave_rx // bytes from the external master
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // fixed data words that follow a command
  function automatic logic [10:0] fixed_words(input logic [7:0] cmd);
    unique case (cmd)
      scbp_pkg::CMD_REG_WRITE: fixed_words = scbp_pkg::REGW_WORDS;
      scbp_pkg::CMD_IIR: fixed_words = scbp_pkg::IIR_WORDS;
      default: fixed_words = 11'h000;
    endcase
  endfunction

  // count words that lead a variable-length command
  function automatic logic [1:0] header_words(input logic [7:0] cmd);
    unique case (cmd)
      scbp_pkg::CMD_FIR: header_words = scbp_pkg::FIR_HDR_WORDS;
      scbp_pkg::CMD_TBS: header_words = scbp_pkg::TBS_HDR_WORDS;
      default: header_words = 2'h0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and slave link
  // ----------------------------------------------------------------
  logic boot_s; // synchronised boot pin
  logic miso_s; // synchronised memory data
  logic ssi_n_s; // synchronised slave select
  logic rx_tog_s; // synchronised byte toggle
  logic [7:0] link_byte; // stable while toggle unchanged
  logic link_tog; // byte event toggle in link domain
  logic link_miso; // slave data out

  scbp_sync #(.W(4)) u_sync (
    .clock(clock),
    .rstn(rstn),
    .din({boot_select, miso_in, slave_select_in_n, link_tog}),
    .dout({boot_s, miso_s, ssi_n_s, rx_tog_s})
  );

  scbp_slave_link u_link (
    .sck(sck_link),
    .rstn(rstn),
    .slave_select_in_n(slave_select_in_n),
    .mosi(mosi_in),
    .miso(link_miso),
    .rx_byte(link_byte),
    .rx_toggle(link_tog)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    scbp_pkg::scbp_state_t state;
    logic [7:0] wait_cnt; // boot pin latch delay
    logic [6:0] div_cnt; // half serial clock period
    logic sck; // master serial clock
    logic cs_n; // memory select
    logic [5:0] bit_cnt; // bits done in transfer
    logic [5:0] nbits; // bits in transfer
    logic [31:0] shift_out; // opcode and address
    logic [23:0] shift_in; // returned bytes
    logic is_cmd; // fetch is a command byte
    logic [15:0] addr; // next memory location
    logic [7:0] cmd; // current command
    logic [10:0] words_left; // data words still to fetch
    logic [1:0] hdr_left; // count words still to fetch
    logic [10:0] n_first; // first fir count
    logic master; // port is bus master
    logic start; // start pulse
    scbp_pkg::scbp_item_t item; // output item
    logic tog_seen; // last toggle taken
    scbp_pkg::scbp_rx_t rx; // output byte
  } scbp_top_t;

  scbp_top_t s_q, s_d;
  logic [10:0] w11; // fetched word, count field

  assign w11 = s_q.shift_in[10:0];

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.start = 1'b0;
    s_d.item.valid = 1'b0;
    s_d.rx.valid = 1'b0;
    s_d.tog_seen = rx_tog_s;
    // slave bytes pass on only once boot is over
    if (s_q.state == scbp_pkg::ST_SLAVE && rx_tog_s != s_q.tog_seen) begin
      s_d.rx.valid = 1'b1;
      s_d.rx.data = link_byte;
    end
    unique case (s_q.state)
      // wait for the boot pin latch time
      scbp_pkg::ST_WAIT: begin
        s_d.wait_cnt = s_q.wait_cnt + 8'h01;
        if (s_q.wait_cnt == 8'(scbp_pkg::BOOT_LATCH_CYC - 1)) begin
          if (boot_s) begin
            s_d.master = 1'b1;
            s_d.is_cmd = 1'b1;
            s_d.addr = scbp_pkg::LOAD_START_ADDR;
            s_d.state = scbp_pkg::ST_START;
          end else begin
            s_d.state = scbp_pkg::ST_SLAVE;
          end
        end
      end
      // open a transfer: select low, load opcode and address
      scbp_pkg::ST_START: begin
        s_d.cs_n = 1'b0;
        s_d.sck = 1'b0;
        s_d.div_cnt = 7'h00;
        s_d.bit_cnt = 6'h00;
        s_d.shift_out = {scbp_pkg::OP_READ, s_q.addr, 8'h00};
        s_d.nbits = s_q.is_cmd ? scbp_pkg::CMD_XFER_BITS : scbp_pkg::DATA_XFER_BITS;
        s_d.state = scbp_pkg::ST_SHIFT;
      end
      // clock out bits, sample on rise, shift on fall
      scbp_pkg::ST_SHIFT: begin
        s_d.div_cnt = s_q.div_cnt + 7'h01;
        if (s_q.div_cnt == 7'(scbp_pkg::SCK_HALF_CYC - 1)) begin
          s_d.div_cnt = 7'h00;
          s_d.sck = ~s_q.sck;
          if (!s_q.sck) begin
            s_d.shift_in = {s_q.shift_in[22:0], miso_s};
          end else begin
            s_d.shift_out = {s_q.shift_out[30:0], 1'b0};
            s_d.bit_cnt = s_q.bit_cnt + 6'h01;
            if (s_q.bit_cnt == s_q.nbits - 6'h01) begin
              s_d.state = scbp_pkg::ST_END;
            end
          end
        end
      end
      // select high for a half period between transfers
      scbp_pkg::ST_END: begin
        s_d.cs_n = 1'b1;
        s_d.div_cnt = s_q.div_cnt + 7'h01;
        if (s_q.div_cnt == 7'(scbp_pkg::SCK_HALF_CYC - 1)) begin
          s_d.div_cnt = 7'h00;
          s_d.state = scbp_pkg::ST_DECODE;
        end
      end
      // act on the fetched byte or word
      scbp_pkg::ST_DECODE: begin
        s_d.item.valid = 1'b1;
        s_d.item.is_cmd = s_q.is_cmd;
        s_d.state = scbp_pkg::ST_START;
        if (s_q.is_cmd) begin
          s_d.cmd = s_q.shift_in[7:0];
          s_d.item.cmd = s_q.shift_in[7:0];
          s_d.item.word = 24'h000000;
          s_d.addr = s_q.addr + 16'h0001;
          s_d.words_left = fixed_words(s_q.shift_in[7:0]);
          s_d.hdr_left = header_words(s_q.shift_in[7:0]);
          s_d.is_cmd = (s_d.words_left == 11'h000) && (s_d.hdr_left == 2'h0);
          if (s_q.shift_in[7:0] == scbp_pkg::CMD_FILTER_START) begin
            s_d.start = 1'b1;
            s_d.master = 1'b0;
            s_d.state = scbp_pkg::ST_SLAVE;
          end
        end else begin
          s_d.item.cmd = s_q.cmd;
          s_d.item.word = s_q.shift_in;
          s_d.addr = s_q.addr + 16'h0003;
          if (s_q.hdr_left == 2'h2) begin
            s_d.n_first = w11; // first fir count
            s_d.hdr_left = 2'h1;
          end else if (s_q.hdr_left == 2'h1) begin
            s_d.hdr_left = 2'h0;
            s_d.words_left = (s_q.cmd == scbp_pkg::CMD_FIR) ? s_q.n_first + w11 : w11;
          end else begin
            s_d.words_left = s_q.words_left - 11'h001;
          end
          s_d.is_cmd = (s_d.words_left == 11'h000) && (s_d.hdr_left == 2'h0);
        end
      end
      // slave operation, port passive
      scbp_pkg::ST_SLAVE: begin
        s_d.master = 1'b0;
        s_d.cs_n = 1'b1;
        s_d.sck = 1'b0;
      end
      default: begin
        s_d.state = scbp_pkg::ST_WAIT;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.cs_n <= 1'b1;
      s_q.state <= scbp_pkg::ST_WAIT;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // pins and outputs
  // ----------------------------------------------------------------
  assign port_serial_clock_out = s_q.sck;
  assign port_serial_clock_oe = s_q.master;
  assign mosi_out = s_q.shift_out[31];
  assign mosi_oe = s_q.master;
  assign memory_select_out_n = s_q.cs_n;
  assign shared_io_oe = 1'b1;
  assign miso_out = link_miso;
  assign miso_oe = (s_q.state == scbp_pkg::ST_SLAVE) && !ssi_n_s;
  assign port_interrupt_out_n = 1'b1;
  assign select_mirror_out_n = 1'b1;
  assign spare_master_selects_n = 3'h7;
  assign load_item = s_q.item;
  assign filters_start = s_q.start;
  assign master_active = s_q.master;
  assign slave_rx = s_q.rx;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  select_idle_a: assert property (!s_q.master |-> memory_select_out_n)
    else $error("memory select low outside boot");
  first_fetch_a: assert property ($rose(s_q.master) |-> s_q.addr == 16'h0010 && s_q.is_cmd)
    else $error("boot does not start with command at 0x10");
  opcode_addr_a: assert property ($fell(memory_select_out_n) |->
      s_q.shift_out[31:24] == 8'h03 && s_q.shift_out[23:8] == s_q.addr)
    else $error("transfer does not open with read opcode and address");
  xfer_len_a: assert property ($rose(memory_select_out_n) && s_q.master |->
      s_q.bit_cnt == (s_q.is_cmd ? 6'd32 : 6'd48))
    else $error("transfer length wrong");
  sck_rate_a: assert property ($changed(port_serial_clock_out) && s_q.master |->
      $past(s_q.div_cnt) == 7'd61)
    else $error("serial clock half period wrong");
  mosi_edge_a: assert property ($changed(mosi_out) && s_q.state == scbp_pkg::ST_SHIFT |->
      $fell(port_serial_clock_out))
    else $error("mosi changed away from falling edge");
  start_slave_a: assert property (filters_start |-> !master_active ##1
      s_q.state == scbp_pkg::ST_SLAVE [*3])
    else $error("start command did not enter slave operation");
  iir_words_a: assert property (s_q.state == scbp_pkg::ST_DECODE && s_q.is_cmd &&
      s_q.shift_in[7:0] == 8'h03 |=> s_q.words_left == 11'd8 && !s_q.is_cmd)
    else $error("iir command does not fetch eight words");
  reserved_a: assert property (port_interrupt_out_n && select_mirror_out_n &&
      spare_master_selects_n == 3'h7)
    else $error("reserved outputs active");
  // enable follows the synchronised select in the same cycle
  miso_release_a: assert property (ssi_n_s |-> !miso_oe)
    else $error("miso driven while deselected");

  // ----------------------------------------------------------------
  // boot choice, fetch addresses and slave gating
  // ----------------------------------------------------------------
  // latch point decides between memory boot and slave operation
  boot_slave_a: assert property (s_q.state == scbp_pkg::ST_WAIT && !boot_s &&
      s_q.wait_cnt == 8'(scbp_pkg::BOOT_LATCH_CYC - 1) |=> s_q.state == scbp_pkg::ST_SLAVE)
    else $error("low boot pin did not select slave operation");
  boot_master_a: assert property (s_q.state == scbp_pkg::ST_WAIT && boot_s &&
      s_q.wait_cnt == 8'(scbp_pkg::BOOT_LATCH_CYC - 1) |=> master_active)
    else $error("high boot pin did not start memory boot");
  reg_words_a: assert property (s_q.state == scbp_pkg::ST_DECODE && s_q.is_cmd &&
      s_q.shift_in[7:0] == 8'h01 |=> s_q.words_left == 11'h002 && !s_q.is_cmd)
    else $error("register write does not fetch two words");
  // stream pointer moves by the size of what was fetched
  cmd_step_a: assert property (s_q.state == scbp_pkg::ST_DECODE && s_q.is_cmd |=>
      s_q.addr == $past(s_q.addr) + 16'h0001)
    else $error("command fetch address did not advance by one");
  addr_step_a: assert property (s_q.state == scbp_pkg::ST_DECODE && !s_q.is_cmd |=>
      s_q.addr == $past(s_q.addr) + 16'h0003)
    else $error("data fetch address did not advance by three");
  sck_idle_a: assert property (memory_select_out_n |-> !port_serial_clock_out)
    else $error("serial clock high while memory deselected");
  rx_gate_a: assert property (slave_rx.valid |-> s_q.state == scbp_pkg::ST_SLAVE)
    else $error("slave byte passed on during boot");

  // ----------------------------------------------------------------
  // covers for the main scenarios
  // ----------------------------------------------------------------

  boot_done_c: cover property (filters_start);
  fir_hdr_c: cover property (s_q.state == scbp_pkg::ST_DECODE && s_q.hdr_left == 2'h1 &&
      s_q.cmd == 8'h02);
  slave_byte_c: cover property (slave_rx.valid);
  data_word_c: cover property (load_item.valid && !load_item.is_cmd);
  mem_boot_c: cover property ($rose(master_active));

endmodule // scbp_top

// *** verif/scbp_eeprom_model.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// configuration memory model
// ----------------------------------------
module scbp_eeprom_model (
  input wire logic sck, // loader serial clock
  input wire logic cs_n, // memory select, active low
  input wire logic mosi, // opcode and address in
  output logic miso // data out
);
  logic [7:0] mem [0:8191]; // 8 kbyte, 16-bit address
  logic [5:0] bit_cnt; // bits taken this frame
  logic [23:0] hdr; // opcode and address
  logic [15:0] last_addr; // address of last frame
  logic [7:0] last_op; // opcode of last frame
  logic [5:0] last_bits; // length of last frame
  logic miso_q = 1'b0; // data bit on the line
  logic [5:0] k; // data bit index
  // take header bits on rising edge, msb first
  always @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt <= 6'h00;
    end else begin
      if (bit_cnt < 6'h18) hdr <= {hdr[22:0], mosi};
      if (bit_cnt == 6'h17) begin
        last_op <= hdr[22:15];
        last_addr <= {hdr[14:0], mosi};
      end
      bit_cnt <= bit_cnt + 6'h01;
    end
  end
  // frame length seen at deselect
  always @(posedge cs_n) last_bits = bit_cnt;
  // data shifted out on falling edge, msb first
  always @(negedge sck) begin
    if (!cs_n && bit_cnt >= 6'h18) begin
      k = bit_cnt - 6'h18;
      miso_q <= mem[last_addr[12:0] + 13'(k[5:3])][3'h7 - k[2:0]];
    end
  end
  // released line shows the last data bit inverted
  assign miso = cs_n ? ~miso_q : miso_q;
endmodule // scbp_eeprom_model

// *** verif/tb.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// bench for the serial boot port
// ----------------------------------------
module tb;
  logic clock = 1'b0; // core clock
  logic rstn = 1'b0; // core reset
  logic sck_link = 1'b0; // host clock, still between frames
  logic boot_select = 1'b0; // boot pin
  logic slave_select_in_n = 1'b1; // host select
  logic mosi_in = 1'b0; // host data
  logic miso_in; // memory data
  logic port_serial_clock_out, port_serial_clock_oe, mosi_out, mosi_oe;
  logic miso_out, miso_oe, memory_select_out_n, shared_io_oe;
  logic port_interrupt_out_n, select_mirror_out_n, master_active, filters_start;
  logic [2:0] spare_master_selects_n;
  scbp_pkg::scbp_item_t load_item;
  scbp_pkg::scbp_rx_t slave_rx;
  int error_cnt = 0; // mismatches
  int checked = 0; // comparisons
  int cyc = 0; // monitor cycles
  int tcnt = 0; // timeout cycles
  int fs_cnt = 0; // start pulses seen
  int last_rise = 0; // cycle of last serial clock rise
  logic sck_p, cs_p, mo_p; // previous samples
  logic [15:0] pa; // next memory location
  logic [7:0] oc; // command owning next words
  scbp_pkg::scbp_item_t ei[$]; // expected items
  logic [15:0] ea[$]; // expected addresses
  logic [5:0] eb[$]; // expected frame lengths
  logic [7:0] rxq[$]; // bytes from the host
  // boot stream: bit 24 marks a command, within size limits
  localparam logic [24:0] STREAM [19] = '{25'h1000001, 25'h0000020, 25'h0123456,
    25'h1000002, 25'h0000001, 25'h0000000, 25'h0abcdef, 25'h1000003, 25'h0100000,
    25'h0100001, 25'h0100002, 25'h0100003, 25'h0100004, 25'h0100005, 25'h0100006,
    25'h0100007, 25'h1000005, 25'h0000000, 25'h1000007};

  always #4 clock = ~clock;

  scbp_top dut_u (.clock(clock), .rstn(rstn), .sck_link(sck_link),
    .boot_select(boot_select), .slave_select_in_n(slave_select_in_n),
    .mosi_in(mosi_in), .miso_in(miso_in), .port_serial_clock_out(port_serial_clock_out),
    .port_serial_clock_oe(port_serial_clock_oe), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
    .miso_out(miso_out), .miso_oe(miso_oe), .memory_select_out_n(memory_select_out_n),
    .shared_io_oe(shared_io_oe), .port_interrupt_out_n(port_interrupt_out_n),
    .select_mirror_out_n(select_mirror_out_n), .spare_master_selects_n(spare_master_selects_n),
    .load_item(load_item), .filters_start(filters_start), .master_active(master_active),
    .slave_rx(slave_rx));

  scbp_eeprom_model mem_u (.sck(port_serial_clock_out), .cs_n(memory_select_out_n),
    .mosi(mosi_out), .miso(miso_in));

  // ----------------------------------------
  // compare and report
  // ----------------------------------------
  task automatic cmp(input string n, input logic [33:0] e, input logic [33:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge clock) begin
    tcnt++;
    if (tcnt == 112000) begin
      cmp("timeout", 34'h0, 34'h1);
      results();
    end
  end

  // watch fetched items, serial clock and data edges
  always @(posedge clock) begin
    cyc++;
    if (slave_rx.valid === 1'b1) rxq.push_back(slave_rx.data);
    if (filters_start === 1'b1) fs_cnt++;
    if (load_item.valid === 1'b1) begin
      if (ei.size() == 0) cmp("extra_item", 34'h0, 34'h1);
      else begin
        cmp("item", ei.pop_front(), load_item);
        cmp("fetch_addr", 34'(ea.pop_front()), 34'(mem_u.last_addr));
        cmp("fetch_op", 34'h03, 34'(mem_u.last_op));
        cmp("fetch_bits", 34'(eb.pop_front()), 34'(mem_u.last_bits));
      end
    end
    if (!memory_select_out_n && port_serial_clock_out && !sck_p) begin
      if (last_rise != 0) cmp("sck_period", 34'(124), 34'(cyc - last_rise));
      last_rise = cyc;
    end
    if (memory_select_out_n) last_rise = 0;
    if (!memory_select_out_n && !cs_p && mosi_out !== mo_p) begin
      cmp("mosi_on_fall", 34'h1, 34'(sck_p & ~port_serial_clock_out));
    end
    sck_p = port_serial_clock_out;
    cs_p = memory_select_out_n;
    mo_p = mosi_out;
  end

  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task automatic do_reset(input logic boot);
    rstn <= 1'b0;
    boot_select <= boot;
    repeat (8) @(posedge clock);
    cmp("sel_in_reset", 34'h1, 34'(memory_select_out_n));
    cmp("oe_in_reset", 34'h0, 34'({port_serial_clock_oe, mosi_oe, miso_oe}));
    rstn <= 1'b1;
    fs_cnt = 0;
    repeat (130) @(posedge clock);
  endtask

  // one host frame of two bytes, link clock only inside the frame
  task automatic host_frame(input logic [15:0] w, output logic [7:0] echo);
    @(posedge clock);
    slave_select_in_n <= 1'b0;
    repeat (4) @(posedge clock);
    #3;
    for (int i = 15; i >= 0; i--) begin
      mosi_in = w[i];
      #6 sck_link = 1'b1;
      if (i < 8) echo[i] = miso_out;
      #6 sck_link = 1'b0;
    end
    cmp("miso_oe_sel", 34'h1, 34'(miso_oe));
    @(posedge clock);
    slave_select_in_n <= 1'b1;
    mosi_in <= ~mosi_in;
    repeat (8) @(posedge clock);
    cmp("miso_oe_idle", 34'h0, 34'(miso_oe));
  endtask

  // queue one stream entry in memory and in the expectations
  task automatic put(input logic [24:0] s);
    scbp_pkg::scbp_item_t it;
    it.valid = 1'b1;
    it.is_cmd = s[24];
    it.cmd = s[24] ? s[7:0] : oc;
    it.word = s[24] ? 24'h0 : s[23:0];
    ea.push_back(pa);
    eb.push_back(s[24] ? 6'h20 : 6'h30);
    if (s[24]) begin
      mem_u.mem[pa[12:0]] = s[7:0];
      oc = s[7:0];
      pa = pa + 16'h1;
    end else begin
      mem_u.mem[pa[12:0]] = s[23:16];
      mem_u.mem[pa[12:0] + 13'h1] = s[15:8];
      mem_u.mem[pa[12:0] + 13'h2] = s[7:0];
      pa = pa + 16'h3;
    end
    ei.push_back(it);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_slave(input logic [7:0] b0, input logic [7:0] b1);
    logic [7:0] echo;
    rxq.delete();
    host_frame({b0, b1}, echo);
    cmp("miso_echo", 34'(b0), 34'(echo));
    cmp("rx_count", 34'h2, 34'(rxq.size()));
    if (rxq.size() == 2) begin
      cmp("rx0", 34'(b0), 34'(rxq[0]));
      cmp("rx1", 34'(b1), 34'(rxq[1]));
    end
    cmp("master_idle", 34'h0, 34'({master_active, port_serial_clock_oe, mosi_oe}));
    cmp("reserved", 34'h1f, 34'({port_interrupt_out_n, select_mirror_out_n,
      spare_master_selects_n}));
  endtask

  task automatic t_boot();
    // header region holds start codes, a wrong origin ends at once
    for (int i = 0; i < 16; i++) mem_u.mem[i] = 8'h07;
    pa = 16'h0010;
    foreach (STREAM[i]) put(STREAM[i]);
    do_reset(1'b1);
    cmp("master_on", 34'h1, 34'(master_active));
    for (int n = 0; n < 108000 && fs_cnt == 0; n++) @(posedge clock);
    repeat (80) @(posedge clock);
    cmp("start_pulses", 34'h1, 34'(fs_cnt));
    cmp("items_left", 34'h0, 34'(ei.size()));
    cmp("master_off", 34'h0, 34'({master_active, port_serial_clock_oe, mosi_oe}));
    cmp("mem_sel_idle", 34'h1, 34'(memory_select_out_n));
    cmp("shared_oe", 34'h1, 34'(shared_io_oe));
  endtask

  initial begin
    do_reset(1'b0);
    t_slave(8'ha5, 8'h3c);
    cmp("no_start", 34'h0, 34'(fs_cnt));
    t_boot();
    t_slave(8'h5a, 8'hc3);
    results();
  end
endmodule // tb
